// >>> design/tmsl_device.sv
// module: thermometer two-wire slave, device end
`timescale 1ns/1ps
`default_nettype none
module tmsl_device
  import tmsl_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TMSL_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link
  tmsl_link_if.device link,
  // address select pins
  input wire logic addr_select_bit2,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit0,
  // register contents shown to the user side
  input wire logic [15:0] temperature,
  output logic [7:0] config_reg,
  output logic [15:0] hysteresis_limit,
  output logic [15:0] over_limit,
  output logic [1:0] pointer_sel,
  output logic soft_reset_pulse,
  output logic timeout_pulse
);
  typedef enum logic [2:0] {
    TMSL_IDLE, TMSL_ADDR, TMSL_CMD, TMSL_WDATA, TMSL_RDATA, TMSL_RACK
  } tmsl_state_t;
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [2:0] asel_a;
    logic [2:0] asel_b;
    logic scl_p;
    logic sda_p;
    tmsl_state_t st;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic ack;
    logic rd;
    logic [1:0] ptr;
    logic [1:0] wbyte;
    logic [7:0] wlo;
    logic [7:0] cfg;
    logic [15:0] hyst;
    logic [15:0] over;
    logic byte2;
    logic sda_o;
    logic sda_oe;
    logic [31:0] tcnt;
    logic srst;
    logic tout;
  } tmsl_dev_t;
  tmsl_dev_t q, d;
  logic scl_r, scl_f, st_c, sp_c;
  logic [15:0] rword;
  always_comb begin
    scl_r = q.scl_s[1] && !q.scl_p;
    scl_f = !q.scl_s[1] && q.scl_p;
    st_c = q.scl_s[1] && q.scl_p && q.sda_p && !q.sda_s[1];
    sp_c = q.scl_s[1] && q.scl_p && !q.sda_p && q.sda_s[1];
  end
  // register selected for read
  always_comb begin
    unique case (q.ptr)
      TMSL_PTR_TEMP: rword = temperature;
      TMSL_PTR_CONFIG: rword = {q.cfg, 8'h00};
      TMSL_PTR_HYST: rword = q.hyst;
      TMSL_PTR_OVER: rword = q.over;
    endcase
  end
  ///////////////////////////////////////////////////////////////////
  // protocol engine
  always_comb begin
    d = q;
    d.scl_s = {q.scl_s[0], link.scl_o};
    d.sda_s = {q.sda_s[0], link.sda};
    d.scl_p = q.scl_s[1];
    d.sda_p = q.sda_s[1];
    // straps are pins too: two flops before the address compare
    d.asel_a = {addr_select_bit2, addr_select_bit1, addr_select_bit0};
    d.asel_b = q.asel_a;
    d.srst = 1'b0;
    d.tout = 1'b0;
    // count only our own low drive
    if (q.sda_oe && !q.sda_o) d.tcnt = q.tcnt + 32'd1;
    else d.tcnt = '0;
    if (sp_c) begin
      d.st = TMSL_IDLE;
      d.sda_oe = 1'b0;
    end else if (st_c) begin
      d.st = TMSL_ADDR;
      d.bitn = TMSL_BIT_COUNT_RESET;
      d.ack = 1'b0;
      d.sda_oe = 1'b0;
    end else if (q.st != TMSL_IDLE && scl_r && !q.ack) begin
      // sample a bit in receive states, or master ack in rack
      if (q.st == TMSL_RACK) begin
        // nack ends transmit; ack after byte one sends byte two unless the pointer is config
        if (q.sda_s[1] || q.byte2 || q.ptr == TMSL_PTR_CONFIG)
          d.st = TMSL_IDLE;
        d.byte2 = 1'b1;
      end else if (q.st != TMSL_RDATA) begin
        d.sh = {q.sh[6:0], q.sda_s[1]};
        d.bitn = q.bitn + 4'd1;
      end else d.bitn = q.bitn + 4'd1;
    end else if (scl_f && q.st != TMSL_IDLE) begin
      if (q.ack) begin
        // end of ack slot
        d.ack = 1'b0;
        d.sda_oe = 1'b0;
        d.bitn = TMSL_BIT_COUNT_RESET;
        if (q.rd) begin
          d.st = TMSL_RDATA;
          d.byte2 = 1'b0;
          d.sh = rword[15:8];
          d.sda_oe = !rword[15];
          d.sda_o = 1'b0;
          d.bitn = TMSL_BIT_COUNT_RESET;
        end
      end else if (q.st == TMSL_RDATA && q.bitn != 4'd8) begin
        d.sh = {q.sh[6:0], 1'b0};
        d.sda_oe = !q.sh[6];
        d.sda_o = 1'b0;
      end else if (q.st == TMSL_RDATA) begin
        d.st = TMSL_RACK;
        d.sda_oe = 1'b0;
      end else if (q.st == TMSL_RACK) begin
        // second byte starts on this falling edge
        if (q.byte2 && q.st == TMSL_RACK) begin
          d.st = TMSL_RDATA;
          d.sh = rword[7:0];
          d.sda_oe = !rword[7];
          d.sda_o = 1'b0;
          d.bitn = TMSL_BIT_COUNT_RESET;
        end
      end else if (q.bitn == 4'd8) begin
        d.sda_o = 1'b0;
        unique case (q.st)
          TMSL_ADDR: begin
            if (q.sh[7:1] == {TMSL_ADDR_FIXED, q.asel_b}) begin
              d.ack = 1'b1;
              d.sda_oe = 1'b1;
              d.rd = q.sh[0];
              d.st = q.sh[0] ? TMSL_RDATA : TMSL_CMD;
            end else d.st = TMSL_IDLE;
          end
          TMSL_CMD: begin
            if (q.sh == TMSL_SOFT_RESET_CMD) begin
              d.srst = 1'b1;
              d.st = TMSL_IDLE;
            end else begin
              d.ptr = q.sh[1:0];
              d.ack = 1'b1;
              d.sda_oe = 1'b1;
              d.st = TMSL_WDATA;
              d.wbyte = 2'd0;
            end
          end
          default: begin
            // data write
            d.ack = 1'b1;
            d.sda_oe = 1'b1;
            d.wbyte = q.wbyte + 2'd1;
            if (q.ptr == TMSL_PTR_CONFIG && q.wbyte == 2'd0) d.cfg = q.sh;
            if (q.wbyte == 2'd0) d.wlo = q.sh;
            if (q.wbyte == 2'd1 && q.ptr == TMSL_PTR_HYST)
              d.hyst = {q.wlo, q.sh};
            if (q.wbyte == 2'd1 && q.ptr == TMSL_PTR_OVER)
              d.over = {q.wlo, q.sh};
          end
        endcase
      end
    end
    // own hold too long: reset engine, release line
    if (q.tcnt >= 32'(TIMEOUT_CYCLES)) begin
      d.st = TMSL_IDLE;
      d.sda_oe = 1'b0;
      d.ack = 1'b0;
      d.tcnt = '0;
      d.tout = 1'b1;
    end
  end
  ///////////////////////////////////////////////////////////////////
  // state register; soft reset acts like power cycling
  always_ff @(posedge clock) begin
    if (!rst_n || q.srst) begin
      q <= '0;
      q.scl_s <= 2'b11;
      q.sda_s <= 2'b11;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.st <= TMSL_IDLE;
      q.ptr <= TMSL_PTR_TEMP;
      q.hyst <= TMSL_REG_RESET;
      q.over <= TMSL_REG_RESET;
    end else begin
      q <= d;
    end
  end
  assign link.sda_s_o = q.sda_o;
  assign link.sda_s_oe = q.sda_oe;
  assign config_reg = q.cfg;
  assign hysteresis_limit = q.hyst;
  assign over_limit = q.over;
  assign pointer_sel = q.ptr;
  assign soft_reset_pulse = q.srst;
  assign timeout_pulse = q.tout;
endmodule // tmsl_device
`default_nettype wire

// >>> design/tmsl_pkg.sv
// package: constants shared by both ends of the two-wire link
package tmsl_pkg;
  localparam logic [7:0] TMSL_SOFT_RESET_CMD = 8'h54;
  localparam logic [3:0] TMSL_ADDR_FIXED = 4'h9;
  localparam logic [1:0] TMSL_PTR_TEMP = 2'h0;
  localparam logic [1:0] TMSL_PTR_CONFIG = 2'h1;
  localparam logic [1:0] TMSL_PTR_HYST = 2'h2;
  localparam logic [1:0] TMSL_PTR_OVER = 2'h3;
  localparam logic [15:0] TMSL_REG_RESET = 16'h0000;
  localparam int TMSL_TIMEOUT_CYCLES = 4000;
  localparam int TMSL_HALF_BIT_CYCLES = 5;
  localparam logic [3:0] TMSL_BIT_COUNT_RESET = 4'h0;
endpackage

// >>> design/tmsl_link_if.sv
// interface: bus clock and open-drain data line between master and device
`timescale 1ns/1ps
`default_nettype none
interface tmsl_link_if;
  logic scl_o;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;
  // wired-and with pull-up
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport master (output scl_o, output sda_m_o, output sda_m_oe,
    input sda);
  modport device (input scl_o, output sda_s_o, output sda_s_oe,
    input sda);
endinterface
`default_nettype wire

// >>> design/tmsl_master.sv
// module: two-wire bus master, the far end
`timescale 1ns/1ps
`default_nettype none
module tmsl_master
  import tmsl_pkg::*;
#(
  parameter int HALF = TMSL_HALF_BIT_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link
  tmsl_link_if.master link,
  // command: addr byte (with r/w), cmd byte, count of data bytes
  input wire logic req,
  input wire logic [7:0] addr_byte,
  input wire logic [7:0] cmd_byte,
  input wire logic send_cmd,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] nbytes,
  // answer
  output logic busy,
  output logic done,
  output logic nacked,
  output logic [15:0] rd_data
);
  typedef enum logic [1:0] {
    TMSM_IDLE, TMSM_START, TMSM_BIT, TMSM_STOP
  } tmsm_state_t;
  typedef struct packed {
    logic [1:0] sda_s;
    tmsm_state_t st;
    logic [7:0] div;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [2:0] byten;
    logic [2:0] last;
    logic [7:0] sh;
    logic rd;
    logic scl;
    logic sda;
    logic busy;
    logic done;
    logic nack;
    logic [15:0] rdat;
    logic [7:0] cmd;
    logic sendc;
    logic [15:0] wdat;
  } tmsm_t;
  tmsm_t q, d;
  logic tick;
  ///////////////////////////////////////////////////////////////////
  // bit sequencer: four phases per bus clock, scl made by divider
  always_comb begin
    d = q;
    d.sda_s = {q.sda_s[0], link.sda};
    d.done = 1'b0;
    tick = (q.div == 8'(HALF - 1));
    d.div = tick ? 8'd0 : q.div + 8'd1;
    unique case (q.st)
      TMSM_IDLE: begin
        d.div = 8'd0;
        if (req) begin
          d.st = TMSM_START;
          d.busy = 1'b1;
          d.nack = 1'b0;
          d.sh = addr_byte;
          d.rd = addr_byte[0];
          d.cmd = cmd_byte;
          d.sendc = send_cmd;
          d.wdat = wr_data;
          d.bitn = 4'd0;
          d.byten = 3'd0;
          d.last = 3'(nbytes) + (send_cmd ? 3'd1 : 3'd0);
        end
      end
      TMSM_START: if (tick) begin
        d.sda = 1'b0; // start: sda falls while scl high
        d.st = TMSM_BIT;
        d.ph = 2'd0;
      end
      TMSM_BIT: if (tick) begin
        d.ph = q.ph + 2'd1;
        unique case (q.ph)
          2'd0: begin
            d.scl = 1'b0;
          end
          2'd1: begin
            // drive data or ack slot while scl low
            if (q.bitn < 4'd8)
              d.sda = (q.rd && q.byten != 3'd0) ? 1'b1 : q.sh[7];
            else if (q.rd && q.byten != 3'd0)
              d.sda = (q.byten == q.last); // master nack on last
            else d.sda = 1'b1;
          end
          2'd2: begin
            d.scl = 1'b1;
          end
          default: begin
            d.bitn = q.bitn + 4'd1;
            if (q.bitn < 4'd8) begin
              d.sh = {q.sh[6:0], q.sda_s[1]};
            end else begin
              d.bitn = 4'd0;
              d.byten = q.byten + 3'd1;
              if (q.rd && q.byten != 3'd0)
                d.rdat = {q.rdat[7:0], q.sh};
              if (!(q.rd && q.byten != 3'd0) && q.sda_s[1]) begin
                d.nack = 1'b1;
                d.st = TMSM_STOP;
              end else if (q.byten == q.last) d.st = TMSM_STOP;
              d.sh = (q.byten == 3'd0 && q.sendc) ? q.cmd :
                (q.byten == 3'd1 && q.sendc) ? q.wdat[15:8] : q.wdat[7:0];
            end
          end
        endcase
      end
      default: if (tick) begin
        // stop: sda low, scl high, then sda high
        d.ph = q.ph + 2'd1;
        if (q.ph == 2'd0) d.scl = 1'b0;
        if (q.ph == 2'd1) d.sda = 1'b0;
        if (q.ph == 2'd2) d.scl = 1'b1;
        if (q.ph == 2'd3) begin
          d.sda = 1'b1;
          d.st = TMSM_IDLE;
          d.busy = 1'b0;
          d.done = 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
      q.sda_s <= 2'b11;
      q.st <= TMSM_IDLE;
      q.scl <= 1'b1;
      q.sda <= 1'b1;
    end else begin
      q <= d;
    end
  end
  assign link.scl_o = q.scl;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = !q.sda;
  assign busy = q.busy;
  assign done = q.done;
  assign nacked = q.nack;
  assign rd_data = q.rdat;
endmodule // tmsl_master
`default_nettype wire

// >>> tb/tmsl_link_sva.sv
// checker: wire-level properties of the two-wire link
`timescale 1ns/1ps
`default_nettype none
module tmsl_link_sva #(
  parameter int TIMEOUT_CYCLES = 200
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link signals
  input wire logic scl_o,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic sda
);
  // who pulls the wire low
  wire logic s_low = sda_s_oe && !sda_s_o;
  wire logic m_low = sda_m_oe && !sda_m_o;
  logic [15:0] hold_q;
  // run length of the device's own low drive
  always_ff @(posedge clock) begin
    if (!rst_n || !s_low) begin
      hold_q <= 16'h0000;
    end else begin
      hold_q <= hold_q + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // a device low drive (bit or ack) lasts at least eight clock cycles
  sequence dev_low_hold;
    s_low [*8];
  endsequence
  sequence scl_low_run;
    !scl_o [*4];
  endsequence
  sequence scl_high_run;
    scl_o [*4];
  endsequence
  a_dev_pull_low: assert property ($rose(s_low) |-> !scl_o)
    else $error("device pulled sda while scl high");
  a_ack_full_period: assert property ($rose(s_low) |-> dev_low_hold)
    else $error("device low drive too short");
  a_dev_quiet_high: assert property (scl_o && $past(scl_o) |->
    s_low == $past(s_low))
    else $error("device changed sda during scl high");
  a_wire_stable_high: assert property (scl_o && $past(scl_o) &&
    sda != $past(sda) |-> m_low != $past(m_low))
    else $error("sda moved under scl high not by master");
  a_hold_bounded: assert property (int'(hold_q) < TIMEOUT_CYCLES)
    else $error("device held sda low too long");
  a_reset_release: assert property ($rose(rst_n) |-> !s_low)
    else $error("device drives sda after reset");
  a_scl_low_phase: assert property ($fell(scl_o) |-> scl_low_run)
    else $error("scl low phase too short");
  a_scl_high_phase: assert property ($rose(scl_o) |-> scl_high_run)
    else $error("scl high phase too short");
endmodule // tmsl_link_sva
`default_nettype wire

// >>> tb/thermometer_two_wire_slave_tb.sv
// testbench: master and device joined, plus a bit-banged fault link
`timescale 1ns/1ps
`default_nettype none
module thermometer_two_wire_slave_tb;
  import tmsl_pkg::*;
  localparam int TO = 200;
  localparam logic [15:0] TEMP = 16'hC3A5;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic send_cmd = 1'b0;
  logic [7:0] addr_byte = 8'h00;
  logic [7:0] cmd_byte = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic [1:0] nbytes = 2'h0;
  logic [2:0] sel = 3'h5;
  logic busy, done, nacked, srst_p, tmo_p, tmo_f;
  logic [15:0] rd_data, hyst, over;
  logic [7:0] cfg;
  logic [1:0] ptr;
  logic [15:0] wv [3] = '{16'h8181, 16'h0302, 16'h8483};
  int failures = 0;
  int total_checks = 0;
  int srst_cnt = 0;
  int tmo_cnt = 0;
  tmsl_link_if link();
  tmsl_link_if link_f();
  always #4 clock = ~clock;
  // pulse counters
  always @(posedge clock) begin
    if (srst_p === 1'b1) srst_cnt++;
    if (tmo_f === 1'b1 || tmo_p === 1'b1) tmo_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////////
  tmsl_master u_tmsl_master (.clock(clock), .rst_n(rst_n), .link(link),
    .req(req), .addr_byte(addr_byte), .cmd_byte(cmd_byte),
    .send_cmd(send_cmd), .wr_data(wr_data), .nbytes(nbytes), .busy(busy),
    .done(done), .nacked(nacked), .rd_data(rd_data));
  tmsl_device #(.TIMEOUT_CYCLES(TO)) u_tmsl_device (.clock(clock),
    .rst_n(rst_n), .link(link), .addr_select_bit2(sel[2]),
    .addr_select_bit1(sel[1]), .addr_select_bit0(sel[0]),
    .temperature(TEMP), .config_reg(cfg), .hysteresis_limit(hyst),
    .over_limit(over), .pointer_sel(ptr), .soft_reset_pulse(srst_p),
    .timeout_pulse(tmo_p));
  // second device on a link the bench drives by hand
  tmsl_device #(.TIMEOUT_CYCLES(TO)) u_tmsl_device_f (.clock(clock),
    .rst_n(rst_n), .link(link_f), .addr_select_bit2(sel[2]),
    .addr_select_bit1(sel[1]), .addr_select_bit0(sel[0]),
    .temperature(TEMP), .config_reg(), .hysteresis_limit(),
    .over_limit(), .pointer_sel(), .soft_reset_pulse(),
    .timeout_pulse(tmo_f));
  tmsl_link_sva #(.TIMEOUT_CYCLES(TO)) u_tmsl_link_sva (.clock(clock),
    .rst_n(rst_n), .scl_o(link.scl_o), .sda_m_o(link.sda_m_o),
    .sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o),
    .sda_s_oe(link.sda_s_oe), .sda(link.sda));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] adr(input logic rw);
    return {TMSL_ADDR_FIXED, sel, rw};
  endfunction
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one master transaction, bounded wait for done
  task xfer(input logic [7:0] a, input logic [7:0] c, input logic sc,
      input logic [15:0] w, input logic [1:0] n);
    int i;
    addr_byte = a;
    cmd_byte = c;
    send_cmd = sc;
    wr_data = w;
    nbytes = n;
    req = 1'b1;
    @(posedge clock);
    #1 req = 1'b0;
    for (i = 0; i < 5000 && done !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    chk(16'(done), 16'h0001);
    chk(16'(busy), 16'h0000);
  endtask
  // one hand-clocked bit; data moves only while scl is low
  task bb(input logic b);
    link_f.scl_o = 1'b0;
    repeat (10) @(posedge clock);
    #1 link_f.sda_m_oe = !b;
    repeat (10) @(posedge clock);
    #1 link_f.scl_o = 1'b1;
    repeat (20) @(posedge clock);
    #1;
  endtask
  task conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clock);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude;
  end
  initial begin
    logic [1:0] p;
    logic [7:0] a;
    int k;
    link_f.scl_o = 1'b1;
    link_f.sda_m_o = 1'b0;
    link_f.sda_m_oe = 1'b0;
    repeat (3) @(posedge clock);
    #1 rst_n = 1'b1;
    // temperature readable at once after reset
    xfer(adr(1'b1), 8'h00, 1'b0, 16'h0000, 2'h2);
    chk(rd_data, TEMP);
    chk(16'(ptr), 16'(TMSL_PTR_TEMP));
    $display("test read_after_reset done");
    // write each writable register (config, hyst, over), then point and read it back
    for (k = 0; k < 3; k++) begin
      p = 2'(k + 1);
      xfer(adr(1'b0), {6'h00, p}, 1'b1, wv[k], k == 0 ? 2'h1 : 2'h2);
      chk(16'(nacked), 16'h0000);
      xfer(adr(1'b0), {6'h00, p}, 1'b1, 16'h0000, 2'h0);
      xfer(adr(1'b1), 8'h00, 1'b0, 16'h0000, k == 0 ? 2'h1 : 2'h2);
      chk(16'(ptr), 16'(p));
      if (k == 0) chk(16'(rd_data[7:0]), 16'h0081);
      else chk(rd_data, wv[k]);
    end
    chk(16'(cfg), 16'h0081);
    chk(hyst, wv[1]);
    chk(over, wv[2]);
    // first byte only of a two-byte register
    xfer(adr(1'b1), 8'h00, 1'b0, 16'h0000, 2'h1);
    chk(16'(rd_data[7:0]), 16'h0084);
    $display("test write_point_read done");
    // any other command byte is a pointer byte
    xfer(adr(1'b0), 8'hFE, 1'b1, 16'h0000, 2'h0);
    chk(16'(ptr), 16'(TMSL_PTR_HYST));
    chk(16'(nacked), 16'h0000);
    // a foreign address is not answered
    xfer({TMSL_ADDR_FIXED, ~sel, 1'b1}, 8'h00, 1'b0, 16'h0000, 2'h1);
    chk(16'(nacked), 16'h0001);
    // soft reset clears the device and is not acknowledged
    xfer(adr(1'b0), TMSL_SOFT_RESET_CMD, 1'b1, 16'h0000, 2'h0);
    chk(16'(nacked), 16'h0001);
    chk(16'(srst_cnt), 16'h0001);
    chk(16'(ptr), 16'(TMSL_PTR_TEMP));
    chk({cfg, cfg}, TMSL_REG_RESET);
    chk(hyst | over, TMSL_REG_RESET);
    $display("test commands_and_reset done");
    // someone else's long low never trips the timeout
    link_f.sda_m_oe = 1'b1;
    repeat (3 * TO) @(posedge clock);
    #1 chk(16'(tmo_cnt), 16'h0000);
    a = adr(1'b0);
    for (k = 7; k >= 0; k--) bb(a[k]);
    // scl parked low in the ack slot: device stuck holding sda
    link_f.scl_o = 1'b0;
    repeat (10) @(posedge clock);
    #1 link_f.sda_m_oe = 1'b0;
    repeat (TO + 100) @(posedge clock);
    #1 chk(16'(tmo_cnt), 16'h0001);
    chk(16'(link_f.sda), 16'h0001);
    $display("test bus_timeout done");
    conclude;
  end
endmodule // thermometer_two_wire_slave_tb
`default_nettype wire
